// ### hdl/pfg_port_five.sv
`timescale 1ns/1ps
`default_nettype none

module pfg_port_five (
    input  wire logic                           REF_CLK,
    input  wire logic                           RSTN,
    input  wire logic                           CE,
    input  wire logic [pfg_pkg::PFG_ADDR_W-1:0] ADDR,
    input  wire logic [pfg_pkg::PFG_DATA_W-1:0] WDATA,
    input  wire logic                           WR,
    input  wire logic                           RD,
    output var  logic [pfg_pkg::PFG_DATA_W-1:0] RDATA,
    input  wire logic [pfg_pkg::PFG_DATA_W-1:0] PIN_I,
    output var  logic [pfg_pkg::PFG_DATA_W-1:0] PIN_O,
    output var  logic [pfg_pkg::PFG_DATA_W-1:0] PIN_OE,
    output var  logic [pfg_pkg::PFG_DATA_W-1:0] PULLUP_EN,
    output var  logic                           SEG_ACTIVE
);

    // ------------------------------------------------------------------
    // bus capture
    // ------------------------------------------------------------------
    pfg_pkg::pfg_bus_s bus;

    assign bus.addr  = ADDR;
    assign bus.wdata = WDATA;
    assign bus.wr    = WR;
    assign bus.rd    = RD;

    function automatic logic hit(
        input pfg_pkg::pfg_bus_s              b,
        input logic [pfg_pkg::PFG_ADDR_W-1:0] a
    );
        hit = (b.addr == a);
    endfunction : hit

    // segment outputs claim all eight pins only when the top select bit is set
    function automatic logic seg_claims(
        input logic [pfg_pkg::PFG_SEG_W-1:0] sel
    );
        seg_claims = sel[pfg_pkg::PFG_SEG_TOP];
    endfunction : seg_claims

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [pfg_pkg::PFG_DATA_W-1:0] pin_function_select_reg;
    logic [pfg_pkg::PFG_DATA_W-1:0] output_data_latch_reg;
    logic [pfg_pkg::PFG_DATA_W-1:0] pull_up_select_reg;
    logic [pfg_pkg::PFG_DATA_W-1:0] pin_direction_control_reg;
    logic [pfg_pkg::PFG_SEG_W-1:0]  segment_driver_select_reg;
    logic [pfg_pkg::PFG_DATA_W-1:0] gpio_mask;
    logic [pfg_pkg::PFG_DATA_W-1:0] port_view;
    logic [pfg_pkg::PFG_DATA_W-1:0] rdata_next;

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            pin_function_select_reg <= pfg_pkg::PFG_RST_BYTE;
        end else if (CE && bus.wr && hit(bus, pfg_pkg::PFG_ADDR_PIN_FUNC)) begin
            pin_function_select_reg <= bus.wdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            output_data_latch_reg <= pfg_pkg::PFG_RST_BYTE;
        end else if (CE && bus.wr && hit(bus, pfg_pkg::PFG_ADDR_OUT_LAT)) begin
            output_data_latch_reg <= bus.wdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            pull_up_select_reg <= pfg_pkg::PFG_RST_BYTE;
        end else if (CE && bus.wr && hit(bus, pfg_pkg::PFG_ADDR_PULL_UP)) begin
            pull_up_select_reg <= bus.wdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            pin_direction_control_reg <= pfg_pkg::PFG_RST_BYTE;
        end else if (CE && bus.wr && hit(bus, pfg_pkg::PFG_ADDR_PIN_DIR)) begin
            pin_direction_control_reg <= bus.wdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            segment_driver_select_reg <= pfg_pkg::PFG_RST_SEG;
        end else if (CE && bus.wr && hit(bus, pfg_pkg::PFG_ADDR_LCD_CTL)) begin
            segment_driver_select_reg <=
                bus.wdata[pfg_pkg::PFG_SEG_LSB +: pfg_pkg::PFG_SEG_W];
        end
    end

    // ------------------------------------------------------------------
    // per-pin ownership and read view
    // ------------------------------------------------------------------
    // a set pin mode bit hands the pin to its alternate input function
    genvar gi;
    generate
        for (gi = 0; gi < pfg_pkg::PFG_DATA_W; gi++) begin : g_pin
            assign gpio_mask[gi] = !pin_function_select_reg[gi] &&
                                   !seg_claims(segment_driver_select_reg);
            assign port_view[gi] = pin_direction_control_reg[gi] ?
                                   output_data_latch_reg[gi] :
                                   PIN_I[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // the direction register is write-only, so it reads back as zero
    always_comb begin
        rdata_next = pfg_pkg::PFG_RD_NONE;
        if (bus.rd) begin
            case (bus.addr)
                pfg_pkg::PFG_ADDR_PIN_FUNC: rdata_next = pin_function_select_reg;
                pfg_pkg::PFG_ADDR_OUT_LAT:  rdata_next = port_view;
                pfg_pkg::PFG_ADDR_PULL_UP:  rdata_next = pull_up_select_reg;
                pfg_pkg::PFG_ADDR_LCD_CTL: begin
                    rdata_next = pfg_pkg::PFG_RD_NONE;
                    rdata_next[pfg_pkg::PFG_SEG_LSB +: pfg_pkg::PFG_SEG_W] =
                        segment_driver_select_reg;
                end
                default:                    rdata_next = pfg_pkg::PFG_RD_NONE;
            endcase
        end
    end

    // read data stand for one enabled cycle after the strobe and hold while the clock enable is low
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            RDATA <= pfg_pkg::PFG_RD_NONE;
        end else if (CE) begin
            RDATA <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    // pin outputs follow the registers one cycle later, trading a cycle
    // of latency for glitch-free flop-driven pads
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            PIN_OE <= pfg_pkg::PFG_RST_BYTE;
        end else if (CE) begin
            PIN_OE <= pin_direction_control_reg & gpio_mask;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            PIN_O <= pfg_pkg::PFG_RST_BYTE;
        end else if (CE) begin
            PIN_O <= output_data_latch_reg & gpio_mask;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            PULLUP_EN <= pfg_pkg::PFG_RST_BYTE;
        end else if (CE) begin
            PULLUP_EN <= ~pin_direction_control_reg & pull_up_select_reg;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            SEG_ACTIVE <= 1'b0;
        end else if (CE) begin
            SEG_ACTIVE <= seg_claims(segment_driver_select_reg);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    // pin outputs are flops, so checks on them look one edge back at the
    // registers that fed them

    AST_OE_FOLLOWS_DIR: assert property (
        $past(CE) && $past(RSTN) |->
            PIN_OE == ($past(pin_direction_control_reg) & $past(gpio_mask)))
        else $error("output enable does not follow direction");

    AST_READ_OUT_LATCH: assert property (
        CE && RD && ADDR == pfg_pkg::PFG_ADDR_OUT_LAT |=>
            (RDATA & $past(pin_direction_control_reg)) ==
            ($past(output_data_latch_reg) & $past(pin_direction_control_reg)))
        else $error("output pin read did not return latch");

    AST_READ_IN_PIN: assert property (
        CE && RD && ADDR == pfg_pkg::PFG_ADDR_OUT_LAT |=>
            (RDATA & ~$past(pin_direction_control_reg)) ==
            ($past(PIN_I) & ~$past(pin_direction_control_reg)))
        else $error("input pin read did not return pin level");

    AST_NO_DRIVE_ALT: assert property (
        $past(CE) && $past(RSTN) |->
            ((PIN_OE | PIN_O) & ~$past(gpio_mask)) == pfg_pkg::PFG_RST_BYTE)
        else $error("pin driven while claimed by another function");

    AST_DIR_WRITE_ONLY: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_PIN_DIR ##1 CE && RD &&
            ADDR == pfg_pkg::PFG_ADDR_PIN_DIR |=>
            RDATA == pfg_pkg::PFG_RD_NONE && pin_direction_control_reg ==
            $past(WDATA, 2))
        else $error("direction register not write-only");

    AST_LATCH_STORE: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_OUT_LAT |=>
            output_data_latch_reg == $past(WDATA))
        else $error("output latch write lost");

    AST_PULL_READBACK: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_PULL_UP ##1 CE && !WR && RD &&
            ADDR == pfg_pkg::PFG_ADDR_PULL_UP |=> RDATA == $past(WDATA, 2))
        else $error("pull-up select readback wrong");

    AST_MODE_READBACK: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_PIN_FUNC ##1 CE && !WR && RD &&
            ADDR == pfg_pkg::PFG_ADDR_PIN_FUNC |=> RDATA == $past(WDATA, 2))
        else $error("pin mode readback wrong");

    AST_SEG_TAKEOVER: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_LCD_CTL ##1 CE |=>
            SEG_ACTIVE == $past(WDATA[pfg_pkg::PFG_SEG_TOP], 2) &&
            (SEG_ACTIVE || PIN_OE == $past(pin_direction_control_reg
                & ~pin_function_select_reg)))
        else $error("segment select did not claim pins as expected");

    AST_PULLUP_GATE: assert property (
        $past(CE) && $past(RSTN) |->
            PULLUP_EN == (~$past(pin_direction_control_reg) &
                          $past(pull_up_select_reg)))
        else $error("pull-up enable wrong");

    // stores are checked one edge on, where the written value must already stand
    AST_DIR_STORE: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_PIN_DIR |=>
            pin_direction_control_reg == $past(WDATA))
        else $error("direction write lost");

    // software cannot see the direction, so a read-modify-write of it is unsafe
    AST_DIR_READS_ZERO: assert property (
        CE && RD && ADDR == pfg_pkg::PFG_ADDR_PIN_DIR |=>
            RDATA == pfg_pkg::PFG_RD_NONE)
        else $error("direction register read back nonzero");

    AST_PULL_STORE: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_PULL_UP |=>
            pull_up_select_reg == $past(WDATA))
        else $error("pull-up select write lost");

    // pin mode here only masks the GPIO drive of its pins; the alternate functions live elsewhere
    AST_MODE_STORE: assert property (
        CE && WR && ADDR == pfg_pkg::PFG_ADDR_PIN_FUNC |=>
            pin_function_select_reg == $past(WDATA))
        else $error("pin mode write lost");

    // a low clock enable must hold the register even with a write on the bus
    AST_PULL_FROZEN: assert property (
        !CE |=> $stable(pull_up_select_reg))
        else $error("pull-up select changed while clock enable low");

    // pins given away keep their latch value; only the pad drive is masked
    AST_OUT_FOLLOWS_LATCH: assert property (
        $past(CE) && $past(RSTN) |->
            PIN_O == ($past(output_data_latch_reg) & $past(gpio_mask)))
        else $error("pin output does not follow latch");

    // segment outputs take all eight pins at once; there is no partial claim
    AST_SEG_BLOCKS_PINS: assert property (
        SEG_ACTIVE |-> PIN_OE == pfg_pkg::PFG_RST_BYTE &&
            PIN_O == pfg_pkg::PFG_RST_BYTE)
        else $error("pins driven while segment outputs own them");

    AST_SEG_FOLLOWS_SELECT: assert property (
        $past(CE) && $past(RSTN) |->
            SEG_ACTIVE == $past(segment_driver_select_reg[pfg_pkg::PFG_SEG_TOP]))
        else $error("segment ownership does not follow select");

    // only the low nibble of lcd control exists in this block
    AST_LCD_UPPER_ZERO: assert property (
        CE && RD && ADDR == pfg_pkg::PFG_ADDR_LCD_CTL |=>
            (RDATA >> pfg_pkg::PFG_SEG_W) == pfg_pkg::PFG_RD_NONE)
        else $error("unused lcd control bits read nonzero");

    // a pull-up fighting a driven pin would only waste current
    AST_PULLUP_ONLY_INPUT: assert property (
        (PULLUP_EN & PIN_OE) == pfg_pkg::PFG_RST_BYTE)
        else $error("pull-up on a pin that drives");

endmodule : pfg_port_five

`default_nettype wire

// ### hdl/pfg_pkg.sv
package pfg_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int PFG_ADDR_W = 16;
    localparam int PFG_DATA_W = 8;
    localparam int PFG_SEG_W  = 4;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [PFG_ADDR_W-1:0] PFG_ADDR_PIN_FUNC = 16'hffcc;
    localparam logic [PFG_ADDR_W-1:0] PFG_ADDR_OUT_LAT  = 16'hffd8;
    localparam logic [PFG_ADDR_W-1:0] PFG_ADDR_PULL_UP  = 16'hffe2;
    localparam logic [PFG_ADDR_W-1:0] PFG_ADDR_PIN_DIR  = 16'hffe8;
    localparam logic [PFG_ADDR_W-1:0] PFG_ADDR_LCD_CTL  = 16'hffc0;

    // ------------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------------
    localparam logic [PFG_DATA_W-1:0] PFG_RST_BYTE = 8'h00;
    localparam logic [PFG_SEG_W-1:0]  PFG_RST_SEG  = 4'h0;
    localparam logic [PFG_DATA_W-1:0] PFG_RD_NONE  = 8'h00;
    localparam int                    PFG_SEG_TOP  = 3;
    localparam int                    PFG_SEG_LSB  = 0;

    typedef struct packed {
        logic [PFG_ADDR_W-1:0] addr;
        logic [PFG_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } pfg_bus_s;

endpackage : pfg_pkg

// ### dv/pfg_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module pfg_board_model (
    input  wire logic       clk,
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output var  logic [7:0] pin_i
);
    // --------------------------------------------------------------
    // wire resolution
    // --------------------------------------------------------------
    // a floating pin wanders every cycle so a lucky default never passes
    logic [7:0] float_reg = 8'h5a;

    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_i[i] = pin_o[i];
            end else if (ext_en[i]) begin
                pin_i[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_i[i] = 1'b1;
            end else begin
                pin_i[i] = float_reg[i];
            end
        end
    end
endmodule : pfg_board_model

`default_nettype wire

// ### dv/pfg_port_five_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pfg_port_five_tb_top;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        ce      = 1'b1;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [15:0] addr    = 16'h0000;
    logic [7:0]  wdata   = 8'h00;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  ext_en  = 8'hff;
    logic [7:0]  rdata, pin_i, pin_o, pin_oe, pullup_en, d;
    logic        seg_active;
    int          err_count  = 0;
    int          n_compared = 0;
    int          cyc        = 0;

    always #10 ref_clk = ~ref_clk;

    pfg_port_five pfg_port_five_i (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_I(pin_i), .PIN_O(pin_o),
        .PIN_OE(pin_oe), .PULLUP_EN(pullup_en), .SEG_ACTIVE(seg_active));

    pfg_board_model pfg_board_model_i (.clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));

    // --------------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : reg_rd

    // write and read with no idle cycle between the strobes
    task automatic wr_then_rd(input logic [15:0] a, input logic [7:0] v,
                              output logic [7:0] r);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask : wr_then_rd

    // pin outputs follow the registers one edge after the write edge
    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic summarize();
        $display("compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic test_reset();
        reg_rd(pfg_pkg::PFG_ADDR_PIN_FUNC, d); chk(d, 8'h00);
        settle(); chk(rdata, 8'h00);
        reg_rd(pfg_pkg::PFG_ADDR_OUT_LAT, d); chk(d, 8'h00);
        reg_rd(pfg_pkg::PFG_ADDR_PULL_UP, d); chk(d, 8'h00);
        reg_rd(pfg_pkg::PFG_ADDR_LCD_CTL, d); chk(d, 8'h00);
        reg_rd(16'h1234, d); chk(d, 8'h00);
        chk(pin_oe, 8'h00);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_dir_read();
        ext_en  <= 8'hf0;
        ext_val <= 8'h9c;
        reg_wr(pfg_pkg::PFG_ADDR_OUT_LAT, 8'ha5);
        reg_wr(pfg_pkg::PFG_ADDR_PIN_DIR, 8'h0f);
        settle();
        chk(pin_oe, 8'h0f);
        chk(pin_o, 8'ha5);
        reg_rd(pfg_pkg::PFG_ADDR_OUT_LAT, d); chk(d, 8'h95);
        reg_rd(pfg_pkg::PFG_ADDR_PIN_DIR, d); chk(d, 8'h00);
        $display("test_dir_read done");
    endtask : test_dir_read

    task automatic test_pullup();
        ext_en <= 8'h00;
        reg_wr(pfg_pkg::PFG_ADDR_PULL_UP, 8'hff);
        settle();
        chk(pullup_en, 8'hf0);
        reg_rd(pfg_pkg::PFG_ADDR_PULL_UP, d); chk(d, 8'hff);
        settle();
        chk(rdata, 8'h00);
        reg_rd(pfg_pkg::PFG_ADDR_OUT_LAT, d); chk(d, 8'hf5);
        // a write with the clock enable low must leave the register alone
        @(posedge ref_clk);
        ce <= 1'b0;
        reg_wr(pfg_pkg::PFG_ADDR_PULL_UP, 8'h00);
        ce <= 1'b1;
        reg_rd(pfg_pkg::PFG_ADDR_PULL_UP, d); chk(d, 8'hff);
        $display("test_pullup done");
    endtask : test_pullup

    task automatic test_pin_mode();
        reg_wr(pfg_pkg::PFG_ADDR_PIN_FUNC, 8'h03);
        settle();
        chk(pin_oe, 8'h0c);
        chk(pin_o, 8'ha4);
        reg_rd(pfg_pkg::PFG_ADDR_PIN_FUNC, d); chk(d, 8'h03);
        reg_wr(pfg_pkg::PFG_ADDR_PIN_FUNC, 8'h00);
        $display("test_pin_mode done");
    endtask : test_pin_mode

    task automatic test_segment();
        for (int s = 0; s < 16; s++) begin
            reg_wr(pfg_pkg::PFG_ADDR_LCD_CTL, 8'(s));
            settle();
            chk({7'h00, seg_active}, {7'h00, s[3]});
            chk(pin_oe, s[3] ? 8'h00 : 8'h0f);
            chk(pin_o, s[3] ? 8'h00 : 8'ha5);
        end
        reg_wr(pfg_pkg::PFG_ADDR_LCD_CTL, 8'hf3);
        reg_rd(pfg_pkg::PFG_ADDR_LCD_CTL, d);
        chk(d, 8'h03);
        reg_wr(pfg_pkg::PFG_ADDR_LCD_CTL, 8'h00);
        $display("test_segment done");
    endtask : test_segment

    task automatic test_back_to_back();
        wr_then_rd(pfg_pkg::PFG_ADDR_PULL_UP, 8'h3c, d);
        chk(d, 8'h3c);
        wr_then_rd(pfg_pkg::PFG_ADDR_PIN_FUNC, 8'h81, d);
        chk(d, 8'h81);
        chk(pin_oe, 8'h0e);
        wr_then_rd(pfg_pkg::PFG_ADDR_PIN_DIR, 8'h0f, d);
        chk(d, 8'h00);
        $display("test_back_to_back done");
    endtask : test_back_to_back

    // reset in mid-run must clear the pull-up and pin mode registers and the PIN_OE, PIN_O and PULLUP_EN outputs
    task automatic test_mid_reset();
        @(posedge ref_clk);
        rstn    <= 1'b0;
        ext_en  <= 8'hff;
        ext_val <= 8'h3c;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        reg_rd(pfg_pkg::PFG_ADDR_OUT_LAT, d);
        chk(d, 8'h3c);
        chk(pin_oe, 8'h00);
        chk(pin_o, 8'h00);
        chk(pullup_en, 8'h00);
        reg_rd(pfg_pkg::PFG_ADDR_PULL_UP, d);
        chk(d, 8'h00);
        reg_rd(pfg_pkg::PFG_ADDR_PIN_FUNC, d);
        chk(d, 8'h00);
        $display("test_mid_reset done");
    endtask : test_mid_reset

    // --------------------------------------------------------------
    // run control
    // --------------------------------------------------------------
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        test_reset();
        test_dir_read();
        test_pullup();
        test_pin_mode();
        test_segment();
        test_back_to_back();
        test_mid_reset();
        summarize();
    end
endmodule : pfg_port_five_tb_top

`default_nettype wire
